// ### common/smbus_host_pkg.sv
package smbus_host_pkg;

  // Device register codes sent as the byte after the address byte
  localparam logic [7:0] REG_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] REG_INPUT_CURRENT = 8'h3f;

  // Controller register offsets on the AHB-Lite side
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TARGET = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;

  // Field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_NACK_BIT = 2;
  localparam int TGT_DEV_LSB = 0;
  localparam int TGT_CODE_LSB = 8;

  // Reset values
  localparam logic [6:0] DEV_RESET = 7'h09;
  localparam logic [7:0] CODE_RESET = REG_CHARGE_CURRENT;
  localparam logic [15:0] WDATA_RESET = 16'h0000;

  // Timing: system clock and serial bit rate
  localparam int CLK_HZ = 25_000_000;
  localparam int SCL_HZ = 100_000;
  // Quarter bit, rounded up so no phase is short
  localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

  // Bit engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_BITS = 5'h04,
    ST_STOP = 5'h08,
    ST_GAP = 5'h10
  } state_t;

  // One queued transaction
  typedef struct packed {
    logic rd;
    logic [6:0] dev;
    logic [7:0] code;
  } cmd_t;

endpackage : smbus_host_pkg

// ### design/smbus_host.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module smbus_host #(
  parameter int unsigned QTR_CYC = smbus_host_pkg::QTR_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  smbus_host_pkg::state_t state_r; // Bit engine state
  smbus_host_pkg::cmd_t cmd_r; // Latched transaction
  smbus_host_pkg::cmd_t tgt_r; // Software target register
  logic [15:0] wdata_r; // Software write data
  logic [15:0] wlat_r; // Write data latched at go
  logic [15:0] rdata_r; // Last word read
  logic [7:0] rd_lo_r; // Staged low read byte
  logic [7:0] sh_r; // Byte shifter
  logic [1:0] q_r; // Quarter within a bit
  logic [3:0] bit_r; // Bit within a byte, 8 is ack
  logic [1:0] byte_r; // Byte within a phase
  logic phb_r; // Read second phase
  logic ackbit_r; // Sampled acknowledge level
  logic busy_r;
  logic nack_r;
  logic done_r;
  logic done_pulse_r;
  logic go_r;
  logic go_rd_r;
  logic [11:0] qcnt_r;
  logic tick_r;
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r; // Pin synchronisers
  logic scl_oe_n_r, sda_oe_n_r;
  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic rx_w; // Current byte is received
  logic ack_w; // Master acks this received byte
  logic last_w; // Current byte ends the phase
  logic ap_w; // Valid address phase

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  assign ap_w = hsel && hready && htrans[1];
  assign rx_w = cmd_r.rd && phb_r && (byte_r != 2'd0);
  assign ack_w = (byte_r == 2'd1);
  assign last_w = (!cmd_r.rd && byte_r == 2'd3) ||
                  (cmd_r.rd && !phb_r && byte_r == 2'd1) ||
                  (cmd_r.rd && phb_r && byte_r == 2'd2);

  // Byte to shift out for a given byte slot
  function automatic logic [7:0] tx_of(input logic [1:0] b);
    logic [7:0] v;
    v = 8'hff;
    if (phb_r) begin
      if (b == 2'd0) v = {cmd_r.dev, 1'b1};
    end else if (b == 2'd0) begin
      v = {cmd_r.dev, 1'b0};
    end else if (b == 2'd1) begin
      v = cmd_r.code;
    end else if (b == 2'd2) begin
      v = wlat_r[7:0];
    end else begin
      v = wlat_r[15:8];
    end
    return v;
  endfunction : tx_of

  // Two-flop synchronisers on the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
    end
  end

  // Quarter-bit enable, runs only while busy
  always_ff @(posedge clock) begin
    if (rst || state_r == smbus_host_pkg::ST_IDLE) begin
      qcnt_r <= 12'h000;
      tick_r <= 1'b0;
    end else if (qcnt_r == 12'(QTR_CYC - 1)) begin
      qcnt_r <= 12'h000;
      tick_r <= 1'b1;
    end else begin
      qcnt_r <= qcnt_r + 12'h001;
      tick_r <= 1'b0;
    end
  end

  // Bit engine: start, bytes, stop, bus-free gap
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= smbus_host_pkg::ST_IDLE;
      cmd_r <= '0;
      wlat_r <= 16'h0000;
      rdata_r <= 16'h0000;
      rd_lo_r <= 8'h00;
      sh_r <= 8'hff;
      q_r <= 2'd0;
      bit_r <= 4'd0;
      byte_r <= 2'd0;
      phb_r <= 1'b0;
      ackbit_r <= 1'b1;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      done_pulse_r <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      done_pulse_r <= 1'b0;
      case (state_r)
        smbus_host_pkg::ST_IDLE: begin
          // Go is ignored while busy since only idle looks at it
          if (go_r) begin
            cmd_r <= '{rd: go_rd_r, dev: tgt_r.dev, code: tgt_r.code};
            wlat_r <= wdata_r;
            state_r <= smbus_host_pkg::ST_START;
            q_r <= 2'd0;
            phb_r <= 1'b0;
            byte_r <= 2'd0;
            nack_r <= 1'b0;
            busy_r <= 1'b1;
          end
        end
        smbus_host_pkg::ST_START: begin
          if (tick_r) begin
            case (q_r)
              2'd0: begin
                sda_oe_n_r <= 1'b1;
                q_r <= 2'd1;
              end
              2'd1: begin
                scl_oe_n_r <= 1'b1;
                q_r <= 2'd2;
              end
              2'd2: begin
                // Wait out any clock stretch before the start edge
                if (scl_s_r) begin
                  sda_oe_n_r <= 1'b0;
                  q_r <= 2'd3;
                end
              end
              default: begin
                scl_oe_n_r <= 1'b0;
                q_r <= 2'd0;
                bit_r <= 4'd0;
                sh_r <= tx_of(byte_r);
                state_r <= smbus_host_pkg::ST_BITS;
              end
            endcase
          end
        end
        smbus_host_pkg::ST_BITS: begin
          if (tick_r) begin
            case (q_r)
              2'd0: begin
                // Data changes only while the clock is low
                if (bit_r == 4'd8) begin
                  sda_oe_n_r <= !(rx_w && ack_w);
                end else begin
                  sda_oe_n_r <= sh_r[7];
                end
                q_r <= 2'd1;
              end
              2'd1: begin
                scl_oe_n_r <= 1'b1;
                q_r <= 2'd2;
              end
              2'd2: begin
                // Sample once the line is really high
                if (scl_s_r) begin
                  if (bit_r == 4'd8) begin
                    ackbit_r <= sda_s_r;
                  end else begin
                    sh_r <= {sh_r[6:0], sda_s_r};
                  end
                  q_r <= 2'd3;
                end
              end
              default: begin
                scl_oe_n_r <= 1'b0;
                q_r <= 2'd0;
                if (bit_r != 4'd8) begin
                  bit_r <= bit_r + 4'd1;
                end else if (!rx_w && ackbit_r) begin
                  // Refused byte: abandon with a stop
                  nack_r <= 1'b1;
                  state_r <= smbus_host_pkg::ST_STOP;
                end else begin
                  if (rx_w && ack_w) begin
                    rd_lo_r <= sh_r;
                  end
                  if (rx_w && !ack_w) begin
                    rdata_r <= {sh_r, rd_lo_r};
                  end
                  if (last_w) begin
                    state_r <= smbus_host_pkg::ST_STOP;
                  end else begin
                    byte_r <= byte_r + 2'd1;
                    bit_r <= 4'd0;
                    sh_r <= tx_of(byte_r + 2'd1);
                  end
                end
              end
            endcase
          end
        end
        smbus_host_pkg::ST_STOP: begin
          if (tick_r) begin
            case (q_r)
              2'd0: begin
                sda_oe_n_r <= 1'b0;
                q_r <= 2'd1;
              end
              2'd1: begin
                scl_oe_n_r <= 1'b1;
                q_r <= 2'd2;
              end
              2'd2: begin
                if (scl_s_r) begin
                  sda_oe_n_r <= 1'b1;
                  q_r <= 2'd3;
                end
              end
              default: begin
                q_r <= 2'd0;
                state_r <= smbus_host_pkg::ST_GAP;
              end
            endcase
          end
        end
        smbus_host_pkg::ST_GAP: begin
          // One bit time of free bus after every stop
          if (tick_r) begin
            q_r <= q_r + 2'd1;
            if (q_r == 2'd3) begin
              if (cmd_r.rd && !phb_r && !nack_r) begin
                phb_r <= 1'b1;
                byte_r <= 2'd0;
                state_r <= smbus_host_pkg::ST_START;
              end else begin
                busy_r <= 1'b0;
                done_pulse_r <= 1'b1;
                state_r <= smbus_host_pkg::ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_r <= smbus_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // AHB-Lite address phase capture and read data
  always_ff @(posedge clock) begin
    if (rst) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
      ap_wr_r <= ap_w && hwrite;
      ap_addr_r <= haddr[7:0];
      if (ap_w && !hwrite) begin
        if (haddr[7:0] == smbus_host_pkg::OFF_CTRL) begin
          hrdata_r <= {30'h0, cmd_r.rd, 1'b0};
        end else if (haddr[7:0] == smbus_host_pkg::OFF_STATUS) begin
          hrdata_r <= {29'h0, nack_r, done_r, busy_r};
        end else if (haddr[7:0] == smbus_host_pkg::OFF_TARGET) begin
          hrdata_r <= {16'h0, tgt_r.code, 1'b0, tgt_r.dev};
        end else if (haddr[7:0] == smbus_host_pkg::OFF_WDATA) begin
          hrdata_r <= {16'h0, wdata_r};
        end else if (haddr[7:0] == smbus_host_pkg::OFF_RDATA) begin
          hrdata_r <= {16'h0, rdata_r};
        end else begin
          hrdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge clock) begin
    if (rst) begin
      tgt_r <= '{rd: 1'b0, dev: smbus_host_pkg::DEV_RESET, code: smbus_host_pkg::CODE_RESET};
      wdata_r <= smbus_host_pkg::WDATA_RESET;
      go_r <= 1'b0;
      go_rd_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (ap_wr_r) begin
        if (ap_addr_r == smbus_host_pkg::OFF_CTRL) begin
          go_r <= hwdata[smbus_host_pkg::CTRL_GO_BIT];
          go_rd_r <= hwdata[smbus_host_pkg::CTRL_RD_BIT];
        end else if (ap_addr_r == smbus_host_pkg::OFF_TARGET) begin
          tgt_r.dev <= hwdata[smbus_host_pkg::TGT_DEV_LSB +: 7];
          tgt_r.code <= hwdata[smbus_host_pkg::TGT_CODE_LSB +: 8];
        end else if (ap_addr_r == smbus_host_pkg::OFF_WDATA) begin
          wdata_r <= hwdata[15:0];
        end
      end
    end
  end

  // Sticky done flag, a new completion beats a clear
  always_ff @(posedge clock) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (done_pulse_r) begin
      done_r <= 1'b1;
    end else if (ap_wr_r && ap_addr_r == smbus_host_pkg::OFF_STATUS &&
                 hwdata[smbus_host_pkg::STAT_DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Stop edge: data rises while the clock is released
  sequence s_stop_edge;
    scl_oe_n_r && !sda_oe_n_r ##1 scl_oe_n_r && sda_oe_n_r;
  endsequence
  // First bit of a byte slot, before its own sample shifts the byte
  sequence s_slot(logic [1:0] b);
    state_r == smbus_host_pkg::ST_BITS && byte_r == b && bit_r == 4'd0 && q_r != 2'd3;
  endsequence

  property p_lo_first;
    s_slot(2'd2) and !cmd_r.rd |-> sh_r == wlat_r[7:0];
  endproperty
  a_lo_first: assert property (p_lo_first) else $error("low byte not sent first");

  property p_one_reg_write;
    (state_r == smbus_host_pkg::ST_BITS && !cmd_r.rd && bit_r == 4'd8 && q_r == 2'd3 &&
     tick_r && !ackbit_r) |=> (state_r == smbus_host_pkg::ST_STOP) == $past(byte_r == 2'd3);
  endproperty
  a_one_reg_write: assert property (p_one_reg_write) else $error("write byte count wrong");

  property p_write_addr;
    s_slot(2'd0) and !phb_r |-> sh_r == {cmd_r.dev, 1'b0} ##0 1'b1;
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("address byte not write");

  property p_read_addr;
    s_slot(2'd0) and phb_r |-> sh_r == {cmd_r.dev, 1'b1};
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("address byte not read");

  property p_sda_steady;
    (state_r == smbus_host_pkg::ST_BITS && scl_oe_n_r && $past(scl_oe_n_r)) |->
      $stable(sda_oe_n_r);
  endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("data moved with clock high");

  property p_ack_first;
    (rx_w && ack_w && bit_r == 4'd8 && q_r == 2'd2) |-> !sda_oe_n_r;
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("first read byte not acked");

  property p_nack_second;
    (state_r == smbus_host_pkg::ST_BITS && rx_w && !ack_w && bit_r == 4'd8 && q_r == 2'd2)
      |-> sda_oe_n_r;
  endproperty
  a_nack_second: assert property (p_nack_second) else $error("second byte was acked");

  property p_stop_only;
    s_stop_edge |-> state_r == smbus_host_pkg::ST_STOP ##[1:1000] state_r == smbus_host_pkg::ST_GAP;
  endproperty
  a_stop_only: assert property (p_stop_only) else $error("stop edge outside stop");

  property p_split_read;
    $rose(phb_r) |-> $past(state_r == smbus_host_pkg::ST_GAP) && cmd_r.rd && !nack_r;
  endproperty
  a_split_read: assert property (p_split_read) else $error("read phase not after stop");

  property p_read_commit;
    $changed(rdata_r) |-> $past(rx_w && byte_r == 2'd2 && bit_r == 4'd8);
  endproperty
  a_read_commit: assert property (p_read_commit) else $error("read word updated early");

endmodule : smbus_host

// ### test/smbus_dev_model.sv
`timescale 1ns/1ps
// Behavioural charger register slave on the two-wire bus
module smbus_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h09,
  parameter int LOW_LIMIT = 625000,
  parameter logic [7:0] VOLT_CODE = 8'h15
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  logic scl_q, sda_q; // Wire levels one clock ago
  logic act, rd, macked; // Selected, read mode, master acked
  logic [3:0] bitn; // Bits done in this byte
  logic [3:0] nb; // Bit count after this falling edge
  logic [2:0] idx; // Byte index, 0 is the address
  logic [7:0] sh, tx, ptr, lo, hi; // Shifter, sender, pointer, staging
  logic [3:0] hold; // Stretch length left
  logic [19:0] low_cnt; // Time the clock line has been low
  logic chg_on; // Charging enabled
  logic [15:0] mem [0:255]; // Settings by register code
  assign nb = bitn + 4'h1;

  // Start, stop, sampling, acknowledge and data drive
  always @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst) begin
      act <= 1'b0;
      sda_oe_n <= 1'b1;
      chg_on <= 1'b0;
      for (int i = 0; i < 256; i++) mem[i] <= 16'h0000;
      mem[smbus_host_pkg::REG_INPUT_CURRENT] <= 16'h0080;
    end else if (scl_q && scl && sda_q && !sda) begin
      // Start: new transaction, first fall only ends the start
      act <= 1'b1;
      rd <= 1'b0;
      idx <= 3'h0;
      bitn <= 4'hf;
      sda_oe_n <= 1'b1;
    end else if (scl_q && scl && !sda_q && sda) begin
      // Stop: commit a complete two-byte write only
      act <= 1'b0;
      sda_oe_n <= 1'b1;
      if (act && !rd && idx == 3'h4) begin
        mem[ptr] <= {hi, lo};
        if (ptr == smbus_host_pkg::REG_CHARGE_CURRENT || ptr == VOLT_CODE) chg_on <= 1'b1;
      end
    end else if (act && !scl_q && scl) begin
      // Rising clock: take data in, or the master's answer
      if (bitn < 4'h8 && (!rd || idx == 3'h0)) sh <= {sh[6:0], sda};
      if (bitn == 4'h8) macked <= !sda;
    end else if (act && scl_q && !scl) begin
      bitn <= nb;
      if (nb == 4'h8) begin
        if (rd && idx != 3'h0) begin
          sda_oe_n <= 1'b1;
        end else if (idx == 3'h0) begin
          if (sh[7:1] == DEV_ADDR) begin
            sda_oe_n <= 1'b0;
            rd <= sh[0];
          end else begin
            act <= 1'b0;
          end
        end else if (idx < 3'h4) begin
          sda_oe_n <= 1'b0;
          if (idx == 3'h1) ptr <= sh;
          if (idx == 3'h2) lo <= sh;
          if (idx == 3'h3) hi <= sh;
        end
      end else if (nb == 4'h9) begin
        // Ack clock over: load the next byte to send, if any
        bitn <= 4'h0;
        idx <= idx + 3'h1;
        sda_oe_n <= 1'b1;
        if (rd && idx == 3'h0) begin
          tx <= mem[ptr][7:0];
          sda_oe_n <= mem[ptr][7];
        end else if (rd && idx == 3'h1 && macked) begin
          tx <= mem[ptr][15:8];
          sda_oe_n <= mem[ptr][15];
        end
      end else if (nb != 4'h0 && rd && (idx == 3'h1 || (idx == 3'h2 && macked))) begin
        sda_oe_n <= tx[6];
        tx <= {tx[6:0], 1'b0};
      end
    end
    if (!rst && low_cnt == LOW_LIMIT[19:0]) chg_on <= 1'b0;
  end

  // Hold the clock low a while after each fall when slow
  always @(posedge clock) begin
    if (rst) begin
      scl_oe_n <= 1'b1;
      hold <= 4'h0;
    end else if (slow && act && scl_q && !scl) begin
      scl_oe_n <= 1'b0;
      hold <= 4'hf;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else begin
      scl_oe_n <= 1'b1;
    end
  end

  // Measure how long the clock line stays low
  always @(posedge clock) begin
    if (rst || scl) low_cnt <= 20'h0;
    else if (low_cnt != LOW_LIMIT[19:0]) low_cnt <= low_cnt + 20'h1;
  end
endmodule : smbus_dev_model

// ### test/smbus_host_test.sv
`timescale 1ns/1ps
// Register-level bench: bus calls drive the host, the model answers
module smbus_host_test;
  localparam logic [7:0] VCODE = 8'h15; // Voltage register code
  logic clock, rst, hsel, hwrite, slow;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic dscl_oe_n, dsda_oe_n; // Model's pin enables
  logic scl, sda; // Wire levels with pull-ups
  logic [7:0] codes [0:2]; // Registers exercised
  logic [15:0] vals [0:2]; // Values written to them
  int fails, checked;
  assign scl = scl_oe_n & dscl_oe_n;
  assign sda = sda_oe_n & dsda_oe_n;

  smbus_host #(.QTR_CYC(4)) u_smbus_host (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n)
  );

  smbus_dev_model #(.LOW_LIMIT(4000), .VOLT_CODE(VCODE)) u_smbus_dev_model (
    .clock(clock), .rst(rst), .scl(scl), .sda(sda), .slow(slow),
    .scl_oe_n(dscl_oe_n), .sda_oe_n(dsda_oe_n)
  );

  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // One single transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdv = hrdata;
  endtask : ahb

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Register read with expected value
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(nm, exp, v);
  endtask : rdchk

  // Queue one device transaction and wait for done
  task automatic run(input logic rdop, input logic [6:0] dev, input logic [7:0] code,
                     input logic [15:0] wd);
    logic [31:0] st;
    int n;
    n = 0;
    ahb(1'b1, smbus_host_pkg::OFF_STATUS, 32'h2, st);
    ahb(1'b1, smbus_host_pkg::OFF_TARGET, {16'h0, code, 1'b0, dev}, st);
    ahb(1'b1, smbus_host_pkg::OFF_WDATA, {16'h0, wd}, st);
    ahb(1'b1, smbus_host_pkg::OFF_CTRL, {30'h0, rdop, 1'b1}, st);
    do begin
      ahb(1'b0, smbus_host_pkg::OFF_STATUS, 32'h0, st);
      n++;
    end while (st[1] !== 1'b1 && n < 3000);
    chk("done_seen", 32'h2, st & 32'h2);
  endtask : run

  // Print the verdict and stop
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    results();
  end

  // Main sequence
  initial begin
    logic [31:0] junk;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    slow = 1'b0;
    codes = '{smbus_host_pkg::REG_CHARGE_CURRENT, smbus_host_pkg::REG_INPUT_CURRENT, VCODE};
    vals = '{16'h41a0, 16'h1f80, 16'h3004};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdchk(smbus_host_pkg::OFF_TARGET, 32'h0000_1409, "target_reset");
    rdchk(smbus_host_pkg::OFF_STATUS, 32'h0, "status_reset");
    ahb(1'b1, 8'h20, 32'hffff_ffff, junk);
    rdchk(8'h20, 32'h0, "unmapped");
    chk("charge_off", 32'h0, {31'h0, u_smbus_dev_model.chg_on});
    chk("fixed_pins", 32'h0, {29'h0, hresp, scl_out, sda_out});
    run(1'b1, 7'h09, smbus_host_pkg::REG_INPUT_CURRENT, 16'h0);
    rdchk(smbus_host_pkg::OFF_RDATA, 32'h0000_0080, "input_default");
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 1);
      run(1'b0, 7'h09, codes[i], vals[i]);
      rdchk(smbus_host_pkg::OFF_STATUS, 32'h2, "write_status");
      chk("dev_reg", {16'h0, vals[i]}, {16'h0, u_smbus_dev_model.mem[codes[i]]});
      run(1'b1, 7'h09, codes[i], 16'hffff);
      rdchk(smbus_host_pkg::OFF_STATUS, 32'h2, "read_status");
      rdchk(smbus_host_pkg::OFF_RDATA, {16'h0, vals[i]}, "read_back");
    end
    chk("charge_on", 32'h1, {31'h0, u_smbus_dev_model.chg_on});
    chk("other_reg", 32'h41a0, {16'h0, u_smbus_dev_model.mem[8'h14]});
    run(1'b1, 7'h0a, smbus_host_pkg::REG_CHARGE_CURRENT, 16'h0);
    rdchk(smbus_host_pkg::OFF_STATUS, 32'h6, "nack_status");
    chk("bus_released", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
    rdchk(smbus_host_pkg::OFF_RDATA, 32'h3004, "rdata_kept");
    rdchk(smbus_host_pkg::OFF_CTRL, 32'h2, "ctrl_rd");
    ahb(1'b1, smbus_host_pkg::OFF_STATUS, 32'h2, junk);
    rdchk(smbus_host_pkg::OFF_STATUS, 32'h4, "done_clear");
    results();
  end
endmodule : smbus_host_test
